// ==== rtl/ctau_exec_unit.sv ====
// Execution unit for byte/word transfers, exchanges, add, subtract and AND.
`timescale 1ns/1ps

module ctau_exec_unit
   import ctau_pkg::*;
#(
   parameter int DIV_FAST = CPU_DIV_FAST,
   parameter int DIV_SLOW = CPU_DIV_SLOW
)
(
   input  wire logic               clock_in,
   input  wire logic               srst_in,
   input  wire logic               processor_clock_control_in,
   input  wire logic               instr_valid_in,
   input  wire ctau_instr_t        instr_in,
   input  wire logic [7:0]         mem_rdata_in,
   output logic                    ready_out,
   output logic                    done_out,
   output logic                    illegal_out,
   output logic [1:0]              instr_len_out,
   output logic                    mem_req_out,
   output logic                    mem_we_out,
   output logic [15:0]             mem_addr_out,
   output logic [7:0]              mem_wdata_out,
   output logic [NUM_GPR-1:0][7:0] gpr_out,
   output logic [7:0]              psw_out
);

   // ----------------------------------------------------------------------
   // Per-instruction tables
   // ----------------------------------------------------------------------
   function automatic logic [3:0] op_cycles(input ctau_op_t op);
      case (op)
         OP_MOV_A_R, OP_MOV_R_A, OP_MOV_PSW_A, OP_MOV_A_PSW,
         OP_WORD_TRANSFER_AX_RP, OP_WORD_TRANSFER_RP_AX, OP_ADD_WITH_CARRY_A_IMM,
         OP_SUBTRACT_WITH_BORROW_A_IMM:                           op_cycles = CYC_4;
         OP_XCH_A_HLD, OP_WORD_SWAP_AX_RP,
         OP_SUB_A_ABS, OP_AND_A_ABS:              op_cycles = CYC_8;
         default:                                 op_cycles = CYC_6;
      endcase
   endfunction

   function automatic logic [1:0] op_length(input ctau_op_t op);
      case (op)
         OP_WORD_TRANSFER_AX_RP, OP_WORD_TRANSFER_RP_AX, OP_WORD_SWAP_AX_RP,
         OP_ADD_A_HL:                             op_length = LEN_1;
         OP_MOV_R_IMM, OP_MOV_PSW_IMM, OP_WORD_TRANSFER_RP_IMM, OP_ADD_SADDR_IMM,
         OP_SUB_A_ABS, OP_AND_A_ABS,
         OP_AND_SADDR_IMM:                        op_length = LEN_3;
         default:                                 op_length = LEN_2;
      endcase
   endfunction

   function automatic logic op_reads_mem(input ctau_op_t op);
      op_reads_mem = op inside {OP_MOV_A_HLD, OP_XCH_A_HLD, OP_ADD_A_HL,
                                OP_ADD_SADDR_IMM, OP_SUB_A_ABS, OP_AND_A_ABS,
                                OP_AND_SADDR_IMM};
   endfunction

   function automatic logic op_writes_mem(input ctau_op_t op);
      op_writes_mem = op inside {OP_XCH_A_HLD, OP_ADD_SADDR_IMM, OP_AND_SADDR_IMM};
   endfunction

   // Exchanges and transfers other than those into PSW keep every flag; arithmetic takes all three from
   // the result and AND takes only zero.
   function automatic ctau_flag_set_t op_flags(input ctau_op_t op);
      case (op)
         OP_ADD_A_HL, OP_ADD_SADDR_IMM, OP_ADD_WITH_CARRY_A_IMM, OP_SUBTRACT_WITH_BORROW_A_IMM,
         OP_SUB_A_ABS: op_flags = '{FLG_RESULT, FLG_RESULT, FLG_RESULT};
         OP_AND_A_ABS,
         OP_AND_SADDR_IMM: op_flags = '{FLG_RESULT, FLG_KEEP, FLG_KEEP};
         default: op_flags = '{FLG_KEEP, FLG_KEEP, FLG_KEEP};
      endcase
   endfunction

   function automatic logic apply_flag(input ctau_flag_ctl_t ctl, input logic cur,
                                       input logic res, input logic prior);
      case (ctl)
         FLG_CLEAR:   apply_flag = 1'b0;
         FLG_SET:     apply_flag = 1'b1;
         FLG_RESULT:  apply_flag = res;
         FLG_RESTORE: apply_flag = prior;
         default:     apply_flag = cur;
      endcase
   endfunction

   function automatic logic [15:0] saddr_of(input logic [7:0] off);
      saddr_of = (off < SADDR_WRAP_LIMIT) ? (SADDR_HIGH_PAGE | {8'h00, off})
                                          : (SADDR_LOW_PAGE | {8'h00, off});
   endfunction

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   // Acceptance issues the read, execute holds it on the port, work uses the read data one cycle later and issues
   // any write, hold waits out the documented duration.
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WORK, ST_HOLD} ctau_state_t;

   ctau_state_t              state_ff;
   ctau_instr_t              instr_ff;
   logic [NUM_GPR-1:0][7:0]  gpr_ff;
   logic [7:0]               psw_ff;
   logic [7:0]               prior_psw_ff;
   logic [3:0]               div_cnt_ff;
   logic [3:0]               cyc_cnt_ff;
   logic                     ready_ff;
   logic                     done_ff;
   logic                     illegal_ff;
   logic [1:0]               len_ff;
   logic                     mem_req_ff;
   logic                     mem_we_ff;
   logic [15:0]              mem_addr_ff;
   logic [7:0]               mem_wdata_ff;

   logic                     accept;
   logic                     bad_operand;
   logic                     cpu_tick;
   logic [3:0]               div_last;
   logic [3:0]               nxt_div_cnt;
   logic [3:0]               nxt_cyc_cnt;
   logic [7:0]               acc;
   logic [15:0]              main_ptr;
   logic [15:0]              nxt_addr;
   logic [7:0]               alu_a;
   logic [7:0]               alu_b;
   ctau_alu_op_t             alu_op;
   ctau_alu_out_t            alu_res;
   ctau_flag_set_t           flag_ctl;

   assign acc      = gpr_ff[REG_A];
   assign main_ptr = {gpr_ff[{PAIR_MAIN, 1'b1}], gpr_ff[{PAIR_MAIN, 1'b0}]};
   assign accept   = instr_valid_in && ready_ff;
   assign flag_ctl = op_flags(instr_ff.op);

   // ----------------------------------------------------------------------
   // Operand legality and address generation
   // ----------------------------------------------------------------------
   always_comb begin
      case (instr_in.op)
         OP_MOV_A_R, OP_MOV_R_A: bad_operand = (instr_in.reg_sel == REG_A);
         OP_XCH_A_R: bad_operand = (instr_in.reg_sel == REG_A) ||
                                   (instr_in.reg_sel == REG_X);
         OP_WORD_TRANSFER_AX_RP, OP_WORD_TRANSFER_RP_AX,
         OP_WORD_SWAP_AX_RP: bad_operand = (instr_in.pair_sel == PAIR_WIDE_ACC);
         default: bad_operand = 1'b0;
      endcase
   end

   always_comb begin
      case (instr_in.op)
         OP_MOV_A_HLD, OP_XCH_A_HLD: nxt_addr = main_ptr + {8'h00, instr_in.offset8};
         OP_ADD_A_HL:  nxt_addr = main_ptr;
         OP_ADD_SADDR_IMM, OP_AND_SADDR_IMM: nxt_addr = saddr_of(instr_in.offset8);
         default:      nxt_addr = instr_in.imm16;
      endcase
   end

   // ----------------------------------------------------------------------
   // CPU clock: the divider count advances every base clock, the cycle count once per CPU clock period.
   // ----------------------------------------------------------------------
   assign div_last = processor_clock_control_in ? 4'(DIV_FAST - 1) : 4'(DIV_SLOW - 1);
   assign cpu_tick = (div_cnt_ff == div_last);
   assign nxt_div_cnt = cpu_tick ? 4'h0 : div_cnt_ff + 4'h1;
   assign nxt_cyc_cnt = cpu_tick ? cyc_cnt_ff + 4'h1 : cyc_cnt_ff;

   always_ff @(posedge clock_in) begin
      if (srst_in || accept) begin
         div_cnt_ff <= 4'h0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer and handshake
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state_ff     <= ST_IDLE;
         ready_ff     <= 1'b1;
         done_ff      <= 1'b0;
         illegal_ff   <= 1'b0;
         cyc_cnt_ff   <= 4'h0;
         len_ff       <= 2'h0;
         instr_ff     <= '0;
         prior_psw_ff <= PSW_RESET;
      end else begin
         done_ff    <= 1'b0;
         illegal_ff <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (accept && bad_operand) begin
                  illegal_ff <= 1'b1;
               end else if (accept) begin
                  state_ff     <= ST_EXEC;
                  ready_ff     <= 1'b0;
                  instr_ff     <= instr_in;
                  len_ff       <= op_length(instr_in.op);
                  cyc_cnt_ff   <= 4'h0;
                  prior_psw_ff <= psw_ff;
               end
            end
            ST_EXEC, ST_WORK, ST_HOLD: begin
               state_ff   <= (state_ff == ST_EXEC) ? ST_WORK : ST_HOLD;
               cyc_cnt_ff <= nxt_cyc_cnt;
               // Memory work always ends by the third base clock, inside the
               // shortest duration, so timing never waits on it. Done is raised
               // one base clock ahead so that it stands in the last base clock
               // of the final CPU clock period, where the next take may happen.
               if (nxt_cyc_cnt == op_cycles(instr_ff.op) - 4'h1 &&
                   nxt_div_cnt == div_last) begin
                  state_ff <= ST_IDLE;
                  ready_ff <= 1'b1;
                  done_ff  <= 1'b1;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Memory port: one read at acceptance, one write in the work cycle.
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         mem_req_ff   <= 1'b0;
         mem_we_ff    <= 1'b0;
         mem_addr_ff  <= 16'h0000;
         mem_wdata_ff <= 8'h00;
      end else if (accept && !bad_operand && op_reads_mem(instr_in.op)) begin
         mem_req_ff  <= 1'b1;
         mem_we_ff   <= 1'b0;
         mem_addr_ff <= nxt_addr;
      end else if (state_ff == ST_WORK && op_writes_mem(instr_ff.op)) begin
         mem_req_ff   <= 1'b1;
         mem_we_ff    <= 1'b1;
         mem_wdata_ff <= (instr_ff.op == OP_XCH_A_HLD) ? acc : alu_res.result;
      end else begin
         mem_req_ff <= 1'b0;
         mem_we_ff  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------------
   always_comb begin
      alu_a = acc;
      alu_b = mem_rdata_in;
      case (instr_ff.op)
         OP_ADD_A_HL, OP_SUB_A_ABS: alu_op = (instr_ff.op == OP_ADD_A_HL) ? ALU_ADD : ALU_SUB;
         OP_ADD_WITH_CARRY_A_IMM, OP_SUBTRACT_WITH_BORROW_A_IMM: begin
            alu_op = (instr_ff.op == OP_ADD_WITH_CARRY_A_IMM) ? ALU_ADD : ALU_SUB;
            alu_b  = instr_ff.imm8;
         end
         OP_ADD_SADDR_IMM, OP_AND_SADDR_IMM: begin
            alu_op = (instr_ff.op == OP_ADD_SADDR_IMM) ? ALU_ADD : ALU_AND;
            alu_a  = mem_rdata_in;
            alu_b  = instr_ff.imm8;
         end
         OP_AND_A_ABS: alu_op = ALU_AND;
         default:      alu_op = ALU_PASS;
      endcase
   end

   ctau_alu u_alu (
      .op_in    (alu_op),
      .a_in     (alu_a),
      .b_in     (alu_b),
      .carry_in ((instr_ff.op inside {OP_ADD_WITH_CARRY_A_IMM, OP_SUBTRACT_WITH_BORROW_A_IMM}) && psw_ff[PSW_CARRY_BIT]),
      .res_out  (alu_res)
   );

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         gpr_ff <= {NUM_GPR{GPR_RESET}};
      end else if (state_ff == ST_WORK) begin
         case (instr_ff.op)
            OP_MOV_R_IMM:  gpr_ff[instr_ff.reg_sel] <= instr_ff.imm8;
            OP_MOV_A_R:    gpr_ff[REG_A] <= gpr_ff[instr_ff.reg_sel];
            OP_MOV_R_A:    gpr_ff[instr_ff.reg_sel] <= acc;
            OP_MOV_A_PSW:  gpr_ff[REG_A] <= psw_ff;
            OP_MOV_A_HLD:  gpr_ff[REG_A] <= mem_rdata_in;
            OP_XCH_A_R: begin
               gpr_ff[REG_A]            <= gpr_ff[instr_ff.reg_sel];
               gpr_ff[instr_ff.reg_sel] <= acc;
            end
            OP_XCH_A_HLD:  gpr_ff[REG_A] <= mem_rdata_in;
            OP_WORD_TRANSFER_RP_IMM: begin
               gpr_ff[{instr_ff.pair_sel, 1'b0}] <= instr_ff.imm16[7:0];
               gpr_ff[{instr_ff.pair_sel, 1'b1}] <= instr_ff.imm16[15:8];
            end
            OP_WORD_TRANSFER_AX_RP, OP_WORD_TRANSFER_RP_AX, OP_WORD_SWAP_AX_RP: begin
               if (instr_ff.op != OP_WORD_TRANSFER_RP_AX) begin
                  gpr_ff[REG_X] <= gpr_ff[{instr_ff.pair_sel, 1'b0}];
                  gpr_ff[REG_A] <= gpr_ff[{instr_ff.pair_sel, 1'b1}];
               end
               if (instr_ff.op != OP_WORD_TRANSFER_AX_RP) begin
                  gpr_ff[{instr_ff.pair_sel, 1'b0}] <= gpr_ff[REG_X];
                  gpr_ff[{instr_ff.pair_sel, 1'b1}] <= acc;
               end
            end
            OP_ADD_A_HL, OP_ADD_WITH_CARRY_A_IMM, OP_SUBTRACT_WITH_BORROW_A_IMM, OP_SUB_A_ABS,
            OP_AND_A_ABS: gpr_ff[REG_A] <= alu_res.result;
            default: gpr_ff <= gpr_ff;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Program status word
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         psw_ff <= PSW_RESET;
      end else if (state_ff == ST_WORK) begin
         if (instr_ff.op == OP_MOV_PSW_IMM) begin
            psw_ff <= instr_ff.imm8;
         end else if (instr_ff.op == OP_MOV_PSW_A) begin
            psw_ff <= acc;
         end else begin
            psw_ff[PSW_ZERO_BIT]  <= apply_flag(flag_ctl.zero, psw_ff[PSW_ZERO_BIT],
                                                alu_res.zero, prior_psw_ff[PSW_ZERO_BIT]);
            psw_ff[PSW_HALF_BIT]  <= apply_flag(flag_ctl.half, psw_ff[PSW_HALF_BIT],
                                                alu_res.half, prior_psw_ff[PSW_HALF_BIT]);
            psw_ff[PSW_CARRY_BIT] <= apply_flag(flag_ctl.carry, psw_ff[PSW_CARRY_BIT],
                                                alu_res.carry, prior_psw_ff[PSW_CARRY_BIT]);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign ready_out     = ready_ff;
   assign done_out      = done_ff;
   assign illegal_out   = illegal_ff;
   assign instr_len_out = len_ff;
   assign mem_req_out   = mem_req_ff;
   assign mem_we_out    = mem_we_ff;
   assign mem_addr_out  = mem_addr_ff;
   assign mem_wdata_out = mem_wdata_ff;
   assign gpr_out       = gpr_ff;
   assign psw_out       = psw_ff;

endmodule // ctau_exec_unit

// ==== rtl/ctau_pkg.sv ====
// Shared types and constants for the transfer and arithmetic execution unit.
package ctau_pkg;

   // ----------------------------------------------------------------------
   // Register numbering
   // ----------------------------------------------------------------------
   localparam logic [2:0] REG_X = 3'h0;
   localparam logic [2:0] REG_A = 3'h1;
   localparam logic [1:0] PAIR_WIDE_ACC = 2'h0;
   localparam logic [1:0] PAIR_BC       = 2'h1;
   localparam logic [1:0] PAIR_SECOND   = 2'h2;
   localparam logic [1:0] PAIR_MAIN     = 2'h3;
   localparam int         NUM_GPR       = 8;

   // ----------------------------------------------------------------------
   // Program status word layout and reset value
   // ----------------------------------------------------------------------
   localparam int         PSW_ZERO_BIT  = 6;
   localparam int         PSW_HALF_BIT  = 4;
   localparam int         PSW_CARRY_BIT = 0;
   localparam logic [7:0] PSW_RESET     = 8'h02;
   localparam logic [7:0] GPR_RESET     = 8'h00;

   // ----------------------------------------------------------------------
   // Short direct addressing window
   // ----------------------------------------------------------------------
   localparam logic [7:0]  SADDR_WRAP_LIMIT = 8'h20;
   localparam logic [15:0] SADDR_LOW_PAGE   = 16'hfe00;
   localparam logic [15:0] SADDR_HIGH_PAGE  = 16'hff00;

   // ----------------------------------------------------------------------
   // Instruction lengths (bytes) and durations (CPU clock cycles)
   // ----------------------------------------------------------------------
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;
   localparam logic [3:0] CYC_4 = 4'h4;
   localparam logic [3:0] CYC_6 = 4'h6;
   localparam logic [3:0] CYC_8 = 4'h8;

   // CPU clock divide ratios from the base clock (high and low speed).
   localparam int CPU_DIV_FAST = 1;
   localparam int CPU_DIV_SLOW = 4;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_MOV_R_IMM, OP_MOV_A_R, OP_MOV_R_A, OP_MOV_PSW_IMM, OP_MOV_PSW_A,
      OP_MOV_A_PSW, OP_MOV_A_HLD, OP_XCH_A_R, OP_XCH_A_HLD, OP_WORD_TRANSFER_RP_IMM,
      OP_WORD_TRANSFER_AX_RP, OP_WORD_TRANSFER_RP_AX, OP_WORD_SWAP_AX_RP, OP_ADD_A_HL,
      OP_ADD_SADDR_IMM, OP_ADD_WITH_CARRY_A_IMM, OP_SUBTRACT_WITH_BORROW_A_IMM, OP_SUB_A_ABS,
      OP_AND_A_ABS, OP_AND_SADDR_IMM
   } ctau_op_t;

   typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_PASS} ctau_alu_op_t;

   typedef enum logic [2:0] {
      FLG_KEEP, FLG_CLEAR, FLG_SET, FLG_RESULT, FLG_RESTORE
   } ctau_flag_ctl_t;

   typedef struct packed {
      ctau_flag_ctl_t zero;
      ctau_flag_ctl_t half;
      ctau_flag_ctl_t carry;
   } ctau_flag_set_t;

   typedef struct packed {
      ctau_op_t    op;
      logic [2:0]  reg_sel;
      logic [1:0]  pair_sel;
      logic [7:0]  imm8;
      logic [7:0]  offset8;
      logic [15:0] imm16;
   } ctau_instr_t;

   typedef struct packed {
      logic [7:0] result;
      logic       zero;
      logic       half;
      logic       carry;
   } ctau_alu_out_t;

endpackage

// ==== rtl/ctau_alu.sv ====
// Byte adder, subtractor and AND with zero, half-carry and carry results.
`timescale 1ns/1ps

module ctau_alu
   import ctau_pkg::*;
(
   input  wire ctau_alu_op_t  op_in,
   input  wire logic [7:0]    a_in,
   input  wire logic [7:0]    b_in,
   input  wire logic          carry_in,
   output ctau_alu_out_t      res_out
);

   logic [4:0] low_sum;
   logic [8:0] full_sum;

   always_comb begin
      low_sum  = 5'h0_0;
      full_sum = 9'h0_00;
      res_out  = '0;
      case (op_in)
         ALU_ADD: begin
            low_sum  = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
            full_sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in};
            res_out.result = full_sum[7:0];
            res_out.half   = low_sum[4];
            res_out.carry  = full_sum[8];
         end
         ALU_SUB: begin
            // Bit 4 and bit 8 of the differences are the borrows out.
            low_sum  = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, carry_in};
            full_sum = {1'b0, a_in} - {1'b0, b_in} - {8'h00, carry_in};
            res_out.result = full_sum[7:0];
            res_out.half   = low_sum[4];
            res_out.carry  = full_sum[8];
         end
         ALU_AND: res_out.result = a_in & b_in;
         default: res_out.result = b_in;
      endcase
      res_out.zero = (res_out.result == 8'h00);
   end

endmodule // ctau_alu

// ==== bench/ctau_checker.sv ====
// Concurrent checks on the execution unit ports.
`timescale 1ns/1ps

module ctau_checker
   import ctau_pkg::*;
(
   input wire logic        clock_in,
   input wire logic        srst_in,
   input wire logic        processor_clock_control_in,
   input wire logic        instr_valid_in,
   input wire ctau_instr_t instr_in,
   input wire logic        ready_out,
   input wire logic        done_out,
   input wire logic        illegal_out,
   input wire logic        mem_req_out,
   input wire logic        mem_we_out,
   input wire logic [15:0] mem_addr_out,
   input wire logic [7:0]  psw_out
);
   logic take;
   assign take = instr_valid_in && ready_out;
   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);
   sequence s_take(ctau_op_t op);
      take && processor_clock_control_in && instr_in.op == op;
   endsequence
   sequence s_rd;
      mem_req_out && !mem_we_out;
   endsequence
   sequence s_wr;
      mem_req_out && mem_we_out;
   endsequence
   a_take_ready: assert property (take |=> !ready_out ^ illegal_out)
      else $error("Ready and illegal disagree after a take.");
   a_add_six: assert property (s_take(OP_ADD_A_HL) |=> !done_out [*5] ##1 done_out)
      else $error("Add from pointer is not six cycles.");
   a_add_with_carry_four: assert property (s_take(OP_ADD_WITH_CARRY_A_IMM) |=> !done_out [*3] ##1 done_out)
      else $error("Add with carry is not four cycles.");
   a_slow_clock: assert property (take && !processor_clock_control_in
      && instr_in.op == OP_ADD_WITH_CARRY_A_IMM |-> ##16 done_out) else $error("Slow clock timing wrong.");
   a_swap_eight: assert property (s_take(OP_XCH_A_HLD) |=> !done_out [*7] ##1 done_out)
      else $error("Memory swap is not eight cycles.");
   a_and_keeps: assert property (s_take(OP_AND_A_ABS) |-> ##8
      (psw_out & 8'h11) == ($past(psw_out, 8) & 8'h11)) else $error("AND changed carry bits.");
   a_pair_refused: assert property (take && instr_in.pair_sel == PAIR_WIDE_ACC
      && instr_in.op inside {OP_WORD_TRANSFER_AX_RP, OP_WORD_TRANSFER_RP_AX, OP_WORD_SWAP_AX_RP}
      |=> illegal_out && ready_out) else $error("Wide pair operand accepted.");
   a_swap_refused: assert property (take && instr_in.op == OP_XCH_A_R
      && instr_in.reg_sel <= REG_A |=> illegal_out) else $error("Swap operand accepted.");
   a_rmw_same: assert property (s_take(OP_ADD_SADDR_IMM) |=> s_rd ##2
      (s_wr and (mem_addr_out == $past(mem_addr_out, 2)))) else $error("Write address moved.");
   a_word_flags: assert property (s_take(OP_WORD_TRANSFER_RP_IMM) |=> $stable(psw_out) [*6])
      else $error("Word load touched flags.");
endmodule // ctau_checker

// ==== bench/testbench.sv ====
// Self-checking bench for the transfer and arithmetic execution unit.
`timescale 1ns/1ps

module testbench
   import ctau_pkg::*;
;
   logic                    clock_in = 1'b0;
   logic                    srst_in = 1'b1;
   logic                    processor_clock_control_in = 1'b1;
   logic                    instr_valid_in = 1'b0;
   ctau_instr_t             instr_in = '0;
   logic [7:0]              mem_rdata_in = 8'h00;
   logic [7:0]              rd_val = 8'h00;
   logic                    ready_out, done_out, illegal_out, mem_req_out, mem_we_out;
   logic [1:0]              instr_len_out;
   logic [15:0]             mem_addr_out, rd_addr, wr_addr;
   logic [7:0]              mem_wdata_out, wr_data, psw_out;
   logic [NUM_GPR-1:0][7:0] gpr_out;
   int                      fails = 0;
   int                      compares = 0;

   ctau_exec_unit uut (.clock_in, .srst_in, .processor_clock_control_in, .instr_valid_in,
      .instr_in, .mem_rdata_in, .ready_out, .done_out, .illegal_out, .instr_len_out,
      .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .gpr_out, .psw_out);

   initial forever #20 clock_in = ~clock_in;

   // Read data toggles outside its one valid cycle, so a late sample cannot pass.
   always @(posedge clock_in) begin
      mem_rdata_in <= (mem_req_out && !mem_we_out) ? rd_val : ~mem_rdata_in;
      if (mem_req_out && !mem_we_out) rd_addr <= mem_addr_out;
      if (mem_req_out && mem_we_out) begin
         wr_addr <= mem_addr_out;
         wr_data <= mem_wdata_out;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      if (fails == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // A count of 1 means a refused request, seen as the illegal pulse.
   task automatic run(input ctau_op_t op, input logic [2:0] r, input logic [1:0] p,
      input logic [7:0] i8, input logic [7:0] off, input logic [15:0] i16,
      input logic [7:0] rd, input int n, input logic [1:0] l);
      int k;
      rd_val = rd;
      @(posedge clock_in);
      instr_valid_in <= 1'b1;
      instr_in <= '{op, r, p, i8, off, i16};
      @(posedge clock_in);
      instr_valid_in <= 1'b0;
      k = 0;
      do begin
         @(negedge clock_in);
         k++;
      end while (done_out !== 1'b1 && illegal_out !== 1'b1 && k < 40);
      chk(16'(k), 16'(n));
      if (illegal_out !== 1'b1) chk(16'(instr_len_out), 16'(l));
   endtask

   task automatic t_transfer();
      run(OP_WORD_TRANSFER_RP_IMM, '0, PAIR_MAIN, '0, '0, 16'h1234, '0, 6, LEN_3);
      run(OP_MOV_A_HLD, '0, '0, '0, 8'hf0, '0, 8'h5a, 6, LEN_2);
      chk(rd_addr, 16'h1324);
      chk({gpr_out[1], psw_out}, 16'h5a02);
      run(OP_WORD_TRANSFER_AX_RP, '0, PAIR_WIDE_ACC, '0, '0, '0, '0, 1, LEN_1);
      run(OP_WORD_TRANSFER_RP_AX, '0, PAIR_BC, '0, '0, '0, '0, 4, LEN_1);
      chk({gpr_out[3], gpr_out[2]}, 16'h5a00);
      run(OP_WORD_SWAP_AX_RP, '0, PAIR_MAIN, '0, '0, '0, '0, 8, LEN_1);
      chk({gpr_out[1], gpr_out[0]}, 16'h1234);
      chk({gpr_out[7], gpr_out[6]}, 16'h5a00);
      run(OP_MOV_PSW_IMM, '0, '0, 8'h51, '0, '0, '0, 6, LEN_3);
      chk({gpr_out[1], psw_out}, 16'h1251);
   endtask

   task automatic t_swap();
      run(OP_XCH_A_R, REG_X, '0, '0, '0, '0, '0, 1, LEN_2);
      run(OP_XCH_A_R, REG_A, '0, '0, '0, '0, '0, 1, LEN_2);
      run(OP_XCH_A_R, 3'h3, '0, '0, '0, '0, '0, 6, LEN_2);
      chk({gpr_out[1], gpr_out[3]}, 16'h5a12);
      run(OP_XCH_A_HLD, '0, '0, '0, 8'h01, '0, 8'hc3, 8, LEN_2);
      chk(wr_addr, 16'h5a01);
      chk({wr_data, gpr_out[1]}, 16'h5ac3);
      chk(16'(psw_out), 16'h0051);
   endtask

   task automatic t_arith();
      run(OP_ADD_WITH_CARRY_A_IMM, '0, '0, 8'h3b, '0, '0, '0, 4, LEN_2);
      chk({gpr_out[1], psw_out}, 16'hff00);
      run(OP_ADD_A_HL, '0, '0, '0, '0, '0, 8'h01, 6, LEN_1);
      chk({gpr_out[1], psw_out}, 16'h0051);
      chk(rd_addr, 16'h5a00);
      run(OP_SUB_A_ABS, '0, '0, '0, '0, 16'hbeef, 8'h01, 8, LEN_3);
      chk({gpr_out[1], psw_out}, 16'hff11);
      chk(rd_addr, 16'hbeef);
      run(OP_SUBTRACT_WITH_BORROW_A_IMM, '0, '0, 8'h0e, '0, '0, '0, 4, LEN_2);
      chk({gpr_out[1], psw_out}, 16'hf000);
      run(OP_ADD_SADDR_IMM, '0, '0, 8'h01, 8'h1f, '0, 8'hff, 6, LEN_3);
      chk({wr_data, psw_out}, 16'h0051);
      chk(wr_addr, 16'hff1f);
   endtask

   task automatic t_logic();
      run(OP_AND_A_ABS, '0, '0, '0, '0, 16'h1000, 8'h30, 8, LEN_3);
      chk({gpr_out[1], psw_out}, 16'h3011);
      run(OP_AND_SADDR_IMM, '0, '0, 8'h5a, 8'h20, '0, 8'ha5, 6, LEN_3);
      chk({wr_data, psw_out}, 16'h0051);
      chk(wr_addr, 16'hfe20);
   endtask

   // The slow clock divides by four, so a four-cycle instruction takes sixteen.
   task automatic t_slow();
      @(posedge clock_in);
      processor_clock_control_in <= 1'b0;
      run(OP_ADD_WITH_CARRY_A_IMM, '0, '0, 8'h00, '0, '0, '0, 16, LEN_2);
      chk({gpr_out[1], psw_out}, 16'h3100);
      @(posedge clock_in);
      processor_clock_control_in <= 1'b1;
   endtask

   initial begin
      repeat (3000) @(posedge clock_in);
      fails++;
      stop_test();
   end

   initial begin
      repeat (20) @(posedge clock_in);
      srst_in <= 1'b0;
      t_transfer();
      t_swap();
      t_arith();
      t_logic();
      t_slow();
      stop_test();
   end
endmodule // testbench

bind ctau_exec_unit ctau_checker chk_i (.clock_in, .srst_in, .processor_clock_control_in,
   .instr_valid_in, .instr_in, .ready_out, .done_out, .illegal_out, .mem_req_out,
   .mem_we_out, .mem_addr_out, .psw_out);
